// ---- rtl/uart_fc_channel.sv ----
// One serial channel: baud tick, transmitter, receiver and flow control
`timescale 1ns/1ns
module uart_fc_channel
  import uart_fc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Configuration
  input wire uart_cfg_t cfg_in,
  // Transmit request
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Receive result
  output rx_word_t rx_word_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  // Serial pins
  output logic txd_out,
  input wire logic rxd_in,
  output logic rts_n_out,
  input wire logic cts_n_in
);

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} rx_state_t;

  // Even parity bit over a byte
  function automatic logic even_par(input logic [7:0] d);
    even_par = ^d;
  endfunction

  // Three-stage input synchronisers; stages 2 and 3 must agree
  logic [2:0] rxd_sync_r;
  logic [2:0] cts_sync_r;
  logic rxd_r;
  logic rxd_nxt;
  logic cts_ok_r;
  logic cts_ok_nxt;

  always_comb
  begin
    rxd_nxt = (rxd_sync_r[1] == rxd_sync_r[2]) ? rxd_sync_r[2] : rxd_r;
    cts_ok_nxt = (cts_sync_r[1] == cts_sync_r[2]) ? ~cts_sync_r[2] : cts_ok_r;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      rxd_sync_r <= 3'h7;
      cts_sync_r <= 3'h7;
      rxd_r <= 1'b1;
      cts_ok_r <= 1'b0;
    end
    else
    begin
      rxd_sync_r <= {rxd_sync_r[1:0], rxd_in};
      cts_sync_r <= {cts_sync_r[1:0], cts_n_in};
      rxd_r <= rxd_nxt;
      cts_ok_r <= cts_ok_nxt;
    end
  end

  // Baud generator: any divisor gives arbitrary rates, clamped at the top rate
  logic [15:0] div_cnt_r;
  logic [15:0] div_cnt_nxt;
  logic tick;
  logic [15:0] div_eff;

  always_comb
  begin
    div_eff = (cfg_in.baud_div < DIV_MIN) ? DIV_MIN : cfg_in.baud_div;
    tick = (div_cnt_r == 16'h0000);
    div_cnt_nxt = tick ? div_eff - 16'h0001 : div_cnt_r - 16'h0001;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      div_cnt_r <= 16'h0000;
    else
      div_cnt_r <= div_cnt_nxt;
  end

  // Transmitter
  tx_state_t tx_st_r, tx_st_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_tk_r, tx_tk_nxt;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic tx_par_r, tx_par_nxt;
  logic txd_r, txd_nxt;
  logic tx_go;
  logic tx_rdy_r, tx_rdy_nxt;

  always_comb
  begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_tk_nxt = tx_tk_r;
    tx_bit_nxt = tx_bit_r;
    tx_par_nxt = tx_par_r;
    txd_nxt = txd_r;
    // With hardware handshake, new frames wait for clear-to-send; a running frame always finishes
    tx_go = tx_valid_in && tx_rdy_r;
    if (tx_st_r != TX_IDLE && tick)
      tx_tk_nxt = tx_tk_r + 4'h1;
    case (tx_st_r)
      TX_IDLE:
        if (tx_go)
        begin
          tx_sh_nxt = tx_data_in;
          tx_par_nxt = even_par(tx_data_in);
          tx_tk_nxt = 4'h0;
          tx_bit_nxt = 3'h0;
          txd_nxt = 1'b0;
          tx_st_nxt = TX_START;
        end
      TX_START:
        if (tick && tx_tk_r == TICK_LAST)
        begin
          txd_nxt = tx_sh_r[0];
          tx_st_nxt = TX_DATA;
        end
      TX_DATA:
        if (tick && tx_tk_r == TICK_LAST)
        begin
          tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
          tx_bit_nxt = tx_bit_r + 3'h1;
          if (tx_bit_r == BIT_LAST)
          begin
            txd_nxt = cfg_in.parity_even ? tx_par_r : 1'b1;
            tx_st_nxt = cfg_in.parity_even ? TX_PAR : TX_STOP;
          end
          else
            txd_nxt = tx_sh_r[1];
        end
      TX_PAR:
        if (tick && tx_tk_r == TICK_LAST)
        begin
          txd_nxt = 1'b1;
          tx_st_nxt = TX_STOP;
        end
      TX_STOP:
        if (tick && tx_tk_r == TICK_LAST)
          tx_st_nxt = TX_IDLE; // Exactly one stop bit
      default:
        tx_st_nxt = TX_IDLE;
    endcase
    // Registered ready so take and pin agree; a freshly loaded flow setting shows one cycle late
    tx_rdy_nxt = (tx_st_nxt == TX_IDLE) && (!cfg_in.flow_hw || cts_ok_nxt);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_tk_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_par_r <= 1'b0;
      txd_r <= 1'b1;
      tx_rdy_r <= 1'b1;
    end
    else
    begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_tk_r <= tx_tk_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_par_r <= tx_par_nxt;
      txd_r <= txd_nxt;
      tx_rdy_r <= tx_rdy_nxt;
    end
  end

  assign txd_out = txd_r;
  assign tx_ready_out = tx_rdy_r;

  // Receiver; samples each bit at its middle tick
  rx_state_t rx_st_r, rx_st_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [3:0] rx_tk_r, rx_tk_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic rx_pe_r, rx_pe_nxt;
  rx_word_t rx_word_r, rx_word_nxt;
  logic rx_valid_r, rx_valid_nxt;
  logic rts_n_r, rts_n_nxt;
  logic mid;

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_tk_nxt = rx_tk_r;
    rx_bit_nxt = rx_bit_r;
    rx_pe_nxt = rx_pe_r;
    rx_word_nxt = rx_word_r;
    rx_valid_nxt = rx_valid_r && !rx_ready_in;
    mid = tick && (rx_tk_r == TICK_MID);
    if (rx_st_r != RX_IDLE && tick)
      rx_tk_nxt = rx_tk_r + 4'h1;
    case (rx_st_r)
      RX_IDLE:
        if (!rxd_r)
        begin
          rx_tk_nxt = 4'h0;
          rx_bit_nxt = 3'h0;
          rx_st_nxt = RX_START;
        end
      RX_START:
        if (mid)
        begin
          rx_tk_nxt = TICK_MID + 4'h1;
          // A glitch shorter than half a bit is not a start bit
          rx_st_nxt = rxd_r ? RX_IDLE : RX_DATA;
        end
      RX_DATA:
        if (mid)
        begin
          rx_sh_nxt = {rxd_r, rx_sh_r[7:1]}; // LSB arrives first
          rx_bit_nxt = rx_bit_r + 3'h1;
          if (rx_bit_r == BIT_LAST)
            rx_st_nxt = cfg_in.parity_even ? RX_PAR : RX_STOP;
        end
      RX_PAR:
        if (mid)
        begin
          rx_pe_nxt = rxd_r != even_par(rx_sh_r);
          rx_st_nxt = RX_STOP;
        end
      RX_STOP:
        if (mid)
        begin
          // A byte that finds the holding slot full is dropped; RTS should prevent it
          if (!rx_valid_r || rx_ready_in)
          begin
            rx_word_nxt.data = rx_sh_r;
            rx_word_nxt.parity_err = cfg_in.parity_even && rx_pe_r;
            rx_word_nxt.frame_err = !rxd_r;
            rx_valid_nxt = 1'b1;
          end
          rx_pe_nxt = 1'b0;
          // A low stop bit must end before a new start is hunted, else it reads as one
          rx_st_nxt = rxd_r ? RX_IDLE : RX_WAIT;
        end
      RX_WAIT:
        if (rxd_r)
          rx_st_nxt = RX_IDLE;
      default:
        rx_st_nxt = RX_IDLE;
    endcase
    // With hardware handshake, request-to-send is off whenever no byte can be taken; without it, always on
    rts_n_nxt = cfg_in.flow_hw ? (cfg_in.power_save || rx_valid_nxt) : 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      rx_st_r <= RX_IDLE;
      rx_sh_r <= 8'h00;
      rx_tk_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_pe_r <= 1'b0;
      rx_word_r <= '0;
      rx_valid_r <= 1'b0;
      rts_n_r <= 1'b0;
    end
    else
    begin
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_tk_r <= rx_tk_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_pe_r <= rx_pe_nxt;
      rx_word_r <= rx_word_nxt;
      rx_valid_r <= rx_valid_nxt;
      rts_n_r <= rts_n_nxt;
    end
  end

  assign rx_word_out = rx_word_r;
  assign rx_valid_out = rx_valid_r;
  assign rts_n_out = rts_n_r;

endmodule

// ---- include/uart_fc_pkg.sv ----
// Shared constants and carrier types for the flow-controlled serial port
package uart_fc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MAX_BAUD = 1000000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned DIV_W = 16;
  // Smallest divisor that keeps the 16x tick at or below the 1 Mbps limit; rounded up so the cap holds
  localparam logic [15:0] DIV_MIN = 16'((CLK_HZ + MAX_BAUD * OVERSAMPLE - 1) / (MAX_BAUD * OVERSAMPLE));
  // Reset divisor for 115200 bit/s at 16x oversampling
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / (115200 * OVERSAMPLE));
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Configuration of one port
  typedef struct packed {
    logic [15:0] baud_div;
    logic parity_even;
    logic flow_hw;
    logic power_save;
  } uart_cfg_t;

  // Received byte with its error flags
  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } rx_word_t;
endpackage

// ---- rtl/uart_fc_top.sv ----
// Two independent flow-controlled serial ports with their configuration registers
`timescale 1ns/1ns

// Summary of operation
// - Two independent serial ports, each for commands and data.
// - Programmable divisor gives standard and odd rates, capped at 1 Mbps.
// - Drives transmit data and request-to-send; samples receive data and clear-to-send.
// - Hardware handshake or no flow control; none after reset.
// - With hardware handshake, request-to-send is off when no byte can be taken, including power saving; without it, always on.
// - Frame is 8 data bits, optional even parity, one stop bit.
// - Reset frame format is 8N1.
// - Data bits go least significant first.
// - Pins may be routed to any free module pin.
module uart_fc_top
  import uart_fc_pkg::*;
#(
  parameter int unsigned PORTS = 2
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Configuration, sampled on cfg_load_in
  input wire uart_cfg_t [PORTS-1:0] cfg_in,
  input wire logic [PORTS-1:0] cfg_load_in,
  // Transmit side
  input wire logic [PORTS-1:0][7:0] tx_data_in,
  input wire logic [PORTS-1:0] tx_valid_in,
  output logic [PORTS-1:0] tx_ready_out,
  // Receive side
  output rx_word_t [PORTS-1:0] rx_word_out,
  output logic [PORTS-1:0] rx_valid_out,
  input wire logic [PORTS-1:0] rx_ready_in,
  // Serial pins, routed by the pin mux outside this block
  output logic [PORTS-1:0] txd_out,
  input wire logic [PORTS-1:0] rxd_in,
  output logic [PORTS-1:0] rts_n_out,
  input wire logic [PORTS-1:0] cts_n_in
);

  // Elaboration-time refusal of an empty port set
  if (PORTS < 1)
  begin : g_bad_ports
    $error("PORTS must be at least 1");
  end

  // Per-port configuration registers; reset gives 8N1 with no flow control
  uart_cfg_t [PORTS-1:0] cfg_r;
  uart_cfg_t [PORTS-1:0] cfg_nxt;

  always_comb
  begin
    for (int i = 0; i < PORTS; i++)
      cfg_nxt[i] = cfg_load_in[i] ? cfg_in[i] : cfg_r[i];
  end

  always_ff @(posedge clk_sys_in)
  begin
    for (int i = 0; i < PORTS; i++)
    begin
      if (sys_rst_in)
        cfg_r[i] <= '{baud_div: DIV_RESET, parity_even: 1'b0, flow_hw: 1'b0, power_save: 1'b0};
      else
        cfg_r[i] <= cfg_nxt[i];
    end
  end

  // Independent channels; each pin is a plain port so any free pin can carry it
  for (genvar g = 0; g < PORTS; g++)
  begin : g_port
    uart_fc_channel u_chan (
      .clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in),
      .cfg_in(cfg_r[g]),
      .tx_data_in(tx_data_in[g]),
      .tx_valid_in(tx_valid_in[g]),
      .tx_ready_out(tx_ready_out[g]),
      .rx_word_out(rx_word_out[g]),
      .rx_valid_out(rx_valid_out[g]),
      .rx_ready_in(rx_ready_in[g]),
      .txd_out(txd_out[g]),
      .rxd_in(rxd_in[g]),
      .rts_n_out(rts_n_out[g]),
      .cts_n_in(cts_n_in[g])
    );
  end

endmodule

// ---- test/uart_fc_chk.sv ----
// Port-level assertions for serial port 0 of the two-port block
`timescale 1ns/1ns
module uart_fc_chk
  import uart_fc_pkg::*;
#(
  parameter int unsigned PORTS = 2
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Watched controls and results
  input wire uart_cfg_t [PORTS-1:0] cfg_in,
  input wire logic [PORTS-1:0] cfg_load_in,
  input wire logic [PORTS-1:0] tx_valid_in,
  input wire logic [PORTS-1:0] tx_ready_out,
  input wire rx_word_t [PORTS-1:0] rx_word_out,
  input wire logic [PORTS-1:0] rx_valid_out,
  input wire logic [PORTS-1:0] rx_ready_in,
  input wire logic [PORTS-1:0] txd_out,
  input wire logic [PORTS-1:0] rts_n_out,
  input wire logic [PORTS-1:0] cts_n_in
);
  logic flow_r, flow_nxt, ps_r, ps_nxt;
  // Shadow of the loaded flow settings, cleared by reset like the port's own copy
  always_comb
  begin
    flow_nxt = flow_r;
    ps_nxt = ps_r;
    if (sys_rst_in)
    begin
      flow_nxt = 1'b0;
      ps_nxt = 1'b0;
    end
    else if (cfg_load_in[0])
    begin
      flow_nxt = cfg_in[0].flow_hw;
      ps_nxt = cfg_in[0].power_save;
    end
  end
  // Registers only
  always_ff @(posedge clk_sys_in)
  begin
    flow_r <= flow_nxt;
    ps_r <= ps_nxt;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence tx_take_s;
    tx_valid_in[0] && tx_ready_out[0];
  endsequence
  // Six samples so the three-to-four cycle synchroniser has surely settled
  sequence cts_off_s;
    cts_n_in[0] [*6];
  endsequence
  rst_idle_a: assert property ($fell(sys_rst_in) |-> txd_out[0] && !rts_n_out[0] && !rx_valid_out[0])
    else $error("port not idle after reset");
  txd_idle_a: assert property (tx_ready_out[0] |-> txd_out[0])
    else $error("line not high while transmitter ready");
  tx_start_a: assert property (tx_take_s |=> !txd_out[0] [*8])
    else $error("start bit missing after take");
  tx_busy_a: assert property (tx_take_s |=> !tx_ready_out[0] [*8])
    else $error("transmitter ready during frame");
  cts_block_a: assert property (cts_off_s ##0 flow_r |-> !tx_ready_out[0])
    else $error("ready while clear-to-send off");
  rts_power_a: assert property (flow_r && ps_r && $past(flow_r && ps_r) |-> rts_n_out[0])
    else $error("request-to-send on in power saving");
  rts_held_a: assert property (flow_r && $past(flow_r) && rx_valid_out[0] && !rx_ready_in[0] |=> rts_n_out[0])
    else $error("request-to-send on while word held");
  rts_noflow_a: assert property (!flow_r && !$past(flow_r) |-> !rts_n_out[0])
    else $error("request-to-send off without flow control");
  rx_hold_a: assert property (rx_valid_out[0] && !rx_ready_in[0] |=> rx_valid_out[0] && $stable(rx_word_out[0]))
    else $error("received word changed before accepted");
endmodule
bind uart_fc_top uart_fc_chk #(.PORTS(PORTS)) chk (
  .clk_sys_in, .sys_rst_in, .cfg_in, .cfg_load_in, .tx_valid_in, .tx_ready_out,
  .rx_word_out, .rx_valid_out, .rx_ready_in, .txd_out, .rts_n_out, .cts_n_in
);

// ---- test/uart_peer.sv ----
// Far-side serial peer: captures frames from the port and sends frames to it
`timescale 1ns/1ns
module uart_peer
  import uart_fc_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Serial pins seen from the far side
  input wire logic txd_in,
  output logic rxd_out,
  output logic cts_n_out
);
  int bt = 16 * DIV_RESET;
  logic par_on = 1'b0;
  logic [9:0] seen_q[$];
  logic [9:0] frm;
  // Line idles high and clear-to-send starts asserted
  initial rxd_out = 1'b1;
  initial cts_n_out = 1'b0;
  // Mid-bit capture; word kept as stop, parity, data
  always
  begin
    @(negedge txd_in);
    repeat (bt / 2) @(posedge clk_sys_in);
    frm = '0;
    for (int i = 0; i < 10; i++)
    begin
      if (i < 8 || par_on || i == 9)
        repeat (bt) @(posedge clk_sys_in);
      frm[i] = (i == 8 && !par_on) ? 1'b0 : txd_in;
    end
    seen_q.push_back(frm);
  end
  // One frame, least significant bit first, with chosen parity and stop faults
  task automatic send(input logic [7:0] d, input logic bad_par, input logic stop_v);
    logic [10:0] bits;
    int n;
    // Start, data LSB first, optional parity, stop; each bit held one bit time
    bits = par_on ? {stop_v, ^d ^ bad_par, d, 1'b0} : {1'b0, stop_v, d, 1'b0};
    n = par_on ? 11 : 10;
    @(posedge clk_sys_in);
    for (int i = 0; i < n; i++)
    begin
      rxd_out <= bits[i];
      repeat (bt) @(posedge clk_sys_in);
    end
    rxd_out <= 1'b1;
    repeat (bt) @(posedge clk_sys_in);
  endtask
endmodule

// ---- test/uart_fc_top_tb.sv ----
// Self-checking bench for the two-port flow-controlled serial block
`timescale 1ns/1ns
module uart_fc_top_tb
  import uart_fc_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  uart_cfg_t [1:0] cfg = '0;
  logic [1:0] load = '0, tx_valid = '0, rx_ready = '0;
  logic [1:0] tx_ready, rx_valid, txd, rts_n, rxd, cts_n;
  logic [1:0][7:0] tx_data = '0;
  logic prxd, pcts;
  rx_word_t [1:0] rx_word;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  // Port 0 faces the peer, port 1 loops back onto itself
  assign rxd = {txd[1], prxd};
  assign cts_n = {1'b0, pcts};
  uart_fc_top #(.PORTS(2)) dut (.clk_sys_in, .sys_rst_in, .cfg_in(cfg), .cfg_load_in(load),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_word_out(rx_word),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .txd_out(txd), .rxd_in(rxd), .rts_n_out(rts_n),
    .cts_n_in(cts_n));
  uart_peer peer (.clk_sys_in, .txd_in(txd[0]), .rxd_out(prxd), .cts_n_out(pcts));
  initial forever #25 clk_sys_in = ~clk_sys_in;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cfg_set(input int p, input logic [15:0] div, input logic par, input logic flow, input logic ps);
    @(posedge clk_sys_in);
    cfg[p] <= '{div, par, flow, ps};
    load[p] <= 1'b1;
    @(posedge clk_sys_in);
    load[p] <= 1'b0;
  endtask
  // Request held until the edge that sees ready
  task automatic tx_send(input int p, input logic [7:0] d);
    int n = 0;
    @(posedge clk_sys_in);
    tx_data[p] <= d;
    tx_valid[p] <= 1'b1;
    do @(posedge clk_sys_in); while (tx_ready[p] !== 1'b1 && ++n < 4000);
    check("tx ready", 16'(tx_ready[p]), 16'h0001);
    tx_valid[p] <= 1'b0;
  endtask
  task automatic rx_get(input int p, input logic [9:0] exp);
    int n = 0;
    do @(posedge clk_sys_in); while (rx_valid[p] !== 1'b1 && ++n < 4000);
    check("rx valid", 16'(rx_valid[p]), 16'h0001);
    check("rx word", 16'(rx_word[p]), 16'(exp));
    rx_ready[p] <= 1'b1;
    @(posedge clk_sys_in);
    rx_ready[p] <= 1'b0;
  endtask
  task automatic frm_chk(input logic [9:0] exp);
    for (int n = 0; n < 4000 && peer.seen_q.size() == 0; n++) @(posedge clk_sys_in);
    check("frame", 16'(peer.seen_q[0]), 16'(exp));
    void'(peer.seen_q.pop_front());
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    check("idle", 16'({txd[0], rts_n[0], tx_ready[0], rx_valid[0]}), 16'h000A);
    // Reset format at the reset divisor; a parity bit would turn the stop bit of A5 low
    tx_send(0, 8'hA5);
    frm_chk(10'h2A5);
    peer.send(8'h5A, 1'b0, 1'b1);
    rx_get(0, 10'h168);
    // Divisor below the floor runs at the capped rate, even parity, handshake; second byte waits
    cfg_set(0, 16'h0001, 1'b1, 1'b1, 1'b0);
    peer.bt = 16 * DIV_MIN;
    peer.par_on = 1'b1;
    tx_send(0, 8'h01);
    tx_send(0, 8'h03);
    frm_chk(10'h301);
    frm_chk(10'h203);
    // Good word, parity fault, stop fault
    for (int k = 0; k < 3; k++)
    begin
      peer.send(8'h96, k == 1, k != 2);
      rx_get(0, {8'h96, k == 1, k == 2});
    end
    // Held word and power saving both turn request-to-send off
    peer.send(8'h11, 1'b0, 1'b1);
    check("rts held", 16'(rts_n[0]), 16'h0001);
    rx_get(0, 10'h044);
    repeat (3) @(posedge clk_sys_in);
    check("rts free", 16'(rts_n[0]), 16'h0000);
    cfg_set(0, 16'h0001, 1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge clk_sys_in);
    check("rts power", 16'(rts_n[0]), 16'h0001);
    cfg_set(0, 16'h0001, 1'b1, 1'b1, 1'b0);
    // Clear-to-send off keeps a pending byte back
    peer.cts_n_out <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    tx_data[0] <= 8'h42;
    tx_valid[0] <= 1'b1;
    repeat (40) @(posedge clk_sys_in);
    check("cts hold", 16'({txd[0], tx_ready[0]}), 16'h0002);
    peer.cts_n_out <= 1'b0;
    tx_send(0, 8'h42);
    frm_chk(10'h242);
    // Second port on its own settings, looped back
    cfg_set(1, 16'h0001, 1'b1, 1'b0, 1'b0);
    tx_send(1, 8'hC3);
    rx_get(1, 10'h30C);
    stop_test();
  end
  // Hang guard well above the few thousand cycles the sequence needs
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      stop_test();
    end
  end
endmodule
